// ==== design/router_pkg.sv ====
`default_nettype none
package router_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned MONITOR_DELAY_MS = 20;
   // Longest time, so rounded down
   localparam int unsigned MONITOR_DELAY_CYC =
      (MONITOR_DELAY_MS * CLK_HZ) / 1000;
   localparam logic [3:0] STEP_DIV_CYC = 4'h4;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_ROUTE_A = 8'h00;
   localparam logic [7:0] OFS_ROUTE_B = 8'h04;
   localparam logic [7:0] OFS_ROUTE_C = 8'h08;
   localparam logic [7:0] OFS_INVERT = 8'h0C;
   localparam logic [7:0] OFS_MODE = 8'h10;
   localparam logic [7:0] OFS_STATE = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;

   localparam logic [15:0] ROUTE_A_RST = 16'h0000;
   localparam logic [15:0] ROUTE_B_RST = 16'h0000;
   localparam logic [3:0] ROUTE_C_RST = 4'h0;
   localparam logic [2:0] INVERT_RST = 3'h0;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   // ---------------------------------------------------------------
   // Selector codes and control modes
   // ---------------------------------------------------------------
   localparam int NUM_PINS = 3;
   localparam int NUM_SIGS = 9;
   localparam int DIGIT_W = 4;
   localparam logic [3:0] DIGIT_NONE = 4'h0;
   localparam logic [3:0] DIGIT_PIN1 = 4'h1;
   localparam logic [1:0] MODE_POSITION = 2'h0;
   localparam logic [1:0] MODE_SPEED = 2'h1;
   localparam logic [1:0] MODE_TORQUE = 2'h2;

   // Sticky event bits
   localparam int IRQ_MON_OFF = 0;
   localparam int IRQ_MON_ON = 1;
   localparam int IRQ_ORIGIN = 2;

   // Encoder position
   localparam int ENC_W = 16;
   localparam int ORIGIN_W = 12;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic near;
      logic warning;
      logic brake;
      logic speed_limited;
      logic torque_limited;
      logic servo_ready;
      logic rotating;
      logic speed_match;
      logic position_done;
   } status_sig_t;

   typedef struct packed {
      logic pulse_phase_a;
      logic pulse_phase_a_n;
      logic pulse_phase_b;
      logic pulse_phase_b_n;
      logic origin_pulse;
      logic origin_pulse_n;
   } pulse_out_t;

   // Signals a mode cannot detect are masked off
   function automatic status_sig_t valid_mask(input logic [1:0] mode);
      status_sig_t m;
      m = '1;
      m.position_done = (mode == MODE_POSITION);
      m.near = (mode == MODE_POSITION);
      m.speed_match = (mode == MODE_SPEED);
      m.speed_limited = (mode == MODE_TORQUE);
      return m;
   endfunction

   // OR of every valid signal whose digit selects this pin
   function automatic logic pin_drive(input logic [NUM_SIGS-1:0] sig,
         input logic [NUM_SIGS*DIGIT_W-1:0] dig, input logic [3:0] code);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_SIGS; i++) begin
         if (dig[i*DIGIT_W +: DIGIT_W] == code) begin
            r = r | sig[i];
         end
      end
      return r;
   endfunction

endpackage
`default_nettype wire

// ==== design/safe_stop_monitor.sv ====
`default_nettype none
module safe_stop_monitor
   import router_pkg::*;
#(
   parameter int unsigned DELAY_LIMIT = MONITOR_DELAY_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic safe_stop_in_1,
   input wire logic safe_stop_in_2,
   output logic safety_monitor_out,
   output logic baseblock_out
);

   logic [1:0] meta_reg;
   logic [1:0] sync_reg;
   logic [31:0] lag_reg;

   // ---------------------------------------------------------------
   // Synchroniser: pins are asynchronous to the drive clock
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_reg <= 2'b00;
         sync_reg <= 2'b00;
      end else begin
         meta_reg <= {safe_stop_in_2, safe_stop_in_1};
         sync_reg <= meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // Monitor and baseblock
   // ---------------------------------------------------------------
   // Reset holds baseblock: motor current stays off until both inputs
   // are seen on, which is the safe direction
   always_ff @(posedge core_clk) begin
      if (rst) begin
         safety_monitor_out <= 1'b0;
         baseblock_out <= 1'b1;
      end else begin
         safety_monitor_out <= &sync_reg;
         baseblock_out <= ~(&sync_reg);
      end
   end

   // Cycles the output has disagreed with the synchronised inputs; the
   // raw pins are never read here, so the bound excludes the two flops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lag_reg <= 32'h0000_0000;
      end else if (safety_monitor_out == (&sync_reg))
      begin
         lag_reg <= 32'h0000_0000;
      end else begin
         lag_reg <= lag_reg + 32'h0000_0001;
      end
   end

   chk_monitor_delay_bound: assert property (@(posedge core_clk)
      disable iff (rst) lag_reg < DELAY_LIMIT)
      else $error("safety monitor lags its inputs too long");

   chk_monitor_both_on: assert property (@(posedge core_clk)
      disable iff (rst) (sync_reg == 2'b11) |=> safety_monitor_out)
      else $error("monitor off with both inputs on");

   chk_baseblock_entry: assert property (@(posedge core_clk)
      disable iff (rst) (sync_reg != 2'b11) |=> baseblock_out)
      else $error("baseblock not entered with an input off");

endmodule
`default_nettype wire

// ==== design/encoder_pulse_out.sv ====
`default_nettype none
module encoder_pulse_out
   import router_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ENC_W-1:0] enc_pos,
   input wire logic enc_pos_valid,
   output pulse_out_t pulse_out,
   output logic origin_event
);

   logic [ENC_W-1:0] target_reg;
   logic [ENC_W-1:0] count_reg;
   logic [3:0] div_reg;
   logic step_tick;

   assign step_tick = (div_reg == STEP_DIV_CYC - 4'h1);

   // ---------------------------------------------------------------
   // Target capture and step pacing
   // ---------------------------------------------------------------
   // Pacing keeps edges spaced for line receivers; a large jump in
   // position is emitted as a burst rather than lost
   always_ff @(posedge core_clk) begin
      if (rst) begin
         target_reg <= '0;
         div_reg <= 4'h0;
      end else begin
         if (enc_pos_valid) begin
            target_reg <= enc_pos;
         end
         div_reg <= step_tick ? 4'h0 : div_reg + 4'h1;
      end
   end

   // One count per tick toward the latest position
   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_reg <= '0;
      end else if (step_tick && count_reg != target_reg) begin
         if ($signed(target_reg - count_reg) > 0) begin
            count_reg <= count_reg + 16'h0001;
         end else begin
            count_reg <= count_reg - 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Two-phase and origin outputs, each with its complement
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pulse_out <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
         origin_event <= 1'b0;
      end else begin
         pulse_out.pulse_phase_a <= count_reg[1];
         pulse_out.pulse_phase_a_n <= ~count_reg[1];
         pulse_out.pulse_phase_b <= count_reg[1] ^ count_reg[0];
         pulse_out.pulse_phase_b_n <= ~(count_reg[1] ^ count_reg[0]);
         pulse_out.origin_pulse <= (count_reg[ORIGIN_W-1:0] == '0);
         pulse_out.origin_pulse_n <= (count_reg[ORIGIN_W-1:0] != '0);
         origin_event <= (count_reg[ORIGIN_W-1:0] == '0) &&
            !pulse_out.origin_pulse;
      end
   end

   chk_quadrature_one_edge: assert property (@(posedge core_clk)
      disable iff (rst)
      !(pulse_out.pulse_phase_a != $past(pulse_out.pulse_phase_a) &&
        pulse_out.pulse_phase_b != $past(pulse_out.pulse_phase_b)))
      else $error("both phases changed in one cycle");

   chk_pulse_complement: assert property (@(posedge core_clk)
      disable iff (rst)
      pulse_out.pulse_phase_a != pulse_out.pulse_phase_a_n &&
      pulse_out.pulse_phase_b != pulse_out.pulse_phase_b_n &&
      pulse_out.origin_pulse != pulse_out.origin_pulse_n)
      else $error("pulse output and its complement agree");

endmodule
`default_nettype wire

// ==== design/servo_output_signal_router.sv ====
//
// Contract
// - A selector digit of 1, 2 or 3 routes its signal to pin pair 1, 23 or 25, and 0 routes it nowhere.
// - The first selector register holds position done, speed match, rotating and servo ready in digits 0 to 3.
// - The second holds torque limit, speed limit, brake and warning, and a third register digit 0 routes near.
// - Signals routed to the same pin are ORed together.
// - A signal the current control mode cannot detect is treated as inactive.
// - Inversion bits 0 to 2 invert pins 1, 23 and 25, and none is inverted after reset.
// - The safety monitor is on only while both safe stop inputs are on.
// - The safety monitor follows a change of either input within 20 ms.
// - Encoder position is turned into complementary two-phase and origin pulses.
// - Either safe stop input off puts the drive in baseblock.
`default_nettype none
module servo_output_signal_router
   import router_pkg::*;
#(
   parameter int unsigned MONITOR_DELAY_CYCLES = MONITOR_DELAY_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire status_sig_t status_in,
   input wire logic safe_stop_in_1,
   input wire logic safe_stop_in_2,
   input wire logic [ENC_W-1:0] enc_pos,
   input wire logic enc_pos_valid,
   output logic [NUM_PINS-1:0] seq_pin_out,
   output logic safety_monitor_out,
   output logic baseblock_out,
   output pulse_out_t pulse_out,
   output logic irq
);

   logic [15:0] route_select_a_reg;
   logic [15:0] route_select_b_reg;
   logic [3:0] route_select_c_reg;
   logic [2:0] pin_invert_select_reg;
   logic [1:0] mode_reg;
   logic [2:0] irq_stat_reg;
   logic [2:0] irq_stat_next;
   logic [2:0] irq_mask_reg;
   logic [2:0] irq_set;
   logic [31:0] prdata_next;
   logic monitor_prev_reg;
   logic origin_event;
   logic addr_ok;
   logic wr_en;
   logic done;
   logic [NUM_SIGS*DIGIT_W-1:0] digits;
   logic [NUM_SIGS-1:0] sig_valid;
   logic [NUM_PINS-1:0] pin_next;

   // ---------------------------------------------------------------
   // Safety monitor and encoder pulse output
   // ---------------------------------------------------------------
   safe_stop_monitor #(
      .DELAY_LIMIT(MONITOR_DELAY_CYCLES)
   ) u_monitor (
      .core_clk(core_clk),
      .rst(rst),
      .safe_stop_in_1(safe_stop_in_1),
      .safe_stop_in_2(safe_stop_in_2),
      .safety_monitor_out(safety_monitor_out),
      .baseblock_out(baseblock_out)
   );

   encoder_pulse_out u_pulse (
      .core_clk(core_clk),
      .rst(rst),
      .enc_pos(enc_pos),
      .enc_pos_valid(enc_pos_valid),
      .pulse_out(pulse_out),
      .origin_event(origin_event)
   );

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // One wait state keeps pready a flop output
   assign done = psel & penable & pready;
   assign wr_en = done & pwrite;

   always_comb begin
      addr_ok = 1'b1;
      prdata_next = 32'h0000_0000;
      unique case (paddr)
         OFS_ROUTE_A: prdata_next[15:0] = route_select_a_reg;
         OFS_ROUTE_B: prdata_next[15:0] = route_select_b_reg;
         OFS_ROUTE_C: prdata_next[3:0] = route_select_c_reg;
         OFS_INVERT: prdata_next[2:0] = pin_invert_select_reg;
         OFS_MODE: prdata_next[1:0] = mode_reg;
         OFS_STATE: prdata_next[5:0] = {pulse_out.origin_pulse,
            baseblock_out, safety_monitor_out, seq_pin_out};
         OFS_IRQ_STAT: prdata_next[2:0] = irq_stat_reg;
         OFS_IRQ_MASK: prdata_next[2:0] = irq_mask_reg;
         default: addr_ok = 1'b0;
      endcase
   end

   // Handshake and read data
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~addr_ok;
         prdata <= (psel & ~pwrite) ? prdata_next : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   // Brake inversion is left to software; nothing here blocks it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         route_select_a_reg <= ROUTE_A_RST;
         route_select_b_reg <= ROUTE_B_RST;
         route_select_c_reg <= ROUTE_C_RST;
         pin_invert_select_reg <= INVERT_RST;
         mode_reg <= MODE_RST;
         irq_mask_reg <= IRQ_MASK_RST;
      end else if (wr_en) begin
         unique case (paddr)
            OFS_ROUTE_A: route_select_a_reg <= pwdata[15:0];
            OFS_ROUTE_B: route_select_b_reg <= pwdata[15:0];
            OFS_ROUTE_C: route_select_c_reg <= pwdata[3:0];
            OFS_INVERT: pin_invert_select_reg <= pwdata[2:0];
            OFS_MODE: mode_reg <= pwdata[1:0];
            OFS_IRQ_MASK: irq_mask_reg <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Output routing
   // ---------------------------------------------------------------
   // Digit order matches the status struct, bit 0 upward
   assign digits = {route_select_c_reg, route_select_b_reg,
      route_select_a_reg};
   assign sig_valid = status_in & valid_mask(mode_reg);

   always_comb begin
      for (int p = 0; p < NUM_PINS; p++) begin
         // Digit 0 never matches a pin code, so it routes nowhere
         pin_next[p] = pin_drive(sig_valid, digits,
            DIGIT_PIN1 + 4'(p)) ^ pin_invert_select_reg[p];
      end
   end

   // Registered pins: a selector rewrite cannot glitch a relay
   always_ff @(posedge core_clk) begin
      if (rst) begin
         seq_pin_out <= INVERT_RST;
      end else begin
         seq_pin_out <= pin_next;
      end
   end

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         monitor_prev_reg <= 1'b0;
      end else begin
         monitor_prev_reg <= safety_monitor_out;
      end
   end

   always_comb begin
      irq_set = 3'h0;
      irq_set[IRQ_MON_OFF] = monitor_prev_reg & ~safety_monitor_out;
      irq_set[IRQ_MON_ON] = ~monitor_prev_reg & safety_monitor_out;
      irq_set[IRQ_ORIGIN] = origin_event;
      irq_stat_next = irq_stat_reg;
      if (wr_en && paddr == OFS_IRQ_STAT) begin
         irq_stat_next = irq_stat_reg & ~pwdata[2:0];
      end
      // A new event outranks a clear in the same cycle
      irq_stat_next = irq_stat_next | irq_set;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_stat_reg <= 3'h0;
         irq <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_pin1_single_route: assert property (@(posedge core_clk)
      disable iff (rst)
      (route_select_a_reg == 16'h0100 && route_select_b_reg == 16'h0000
       && route_select_c_reg == 4'h0 && pin_invert_select_reg == 3'h0)
      |=> seq_pin_out[0] == $past(status_in.rotating))
      else $error("rotating signal not routed to pin 1");

   chk_digit_zero_idle: assert property (@(posedge core_clk)
      disable iff (rst)
      (route_select_a_reg == 16'h0000 && route_select_b_reg == 16'h0000
       && route_select_c_reg == 4'h0 && pin_invert_select_reg == 3'h0)
      |=> seq_pin_out == 3'h0)
      else $error("pin driven with all digits at zero");

   chk_or_two_signals: assert property (@(posedge core_clk)
      disable iff (rst)
      (route_select_a_reg == 16'h3300 && route_select_b_reg == 16'h0000
       && route_select_c_reg == 4'h0 && pin_invert_select_reg == 3'h0)
      |=> seq_pin_out[2] ==
         ($past(status_in.rotating) | $past(status_in.servo_ready)))
      else $error("pin 25 is not the OR of its signals");

   chk_invalid_in_mode: assert property (@(posedge core_clk)
      disable iff (rst)
      (mode_reg == MODE_SPEED && route_select_a_reg == 16'h0001
       && route_select_b_reg == 16'h0000 && route_select_c_reg == 4'h0
       && pin_invert_select_reg == 3'h0) |=> !seq_pin_out[0])
      else $error("position done drives a pin in speed control");

   chk_invert_flips: assert property (@(posedge core_clk)
      disable iff (rst)
      (route_select_a_reg == 16'h0000 && route_select_b_reg == 16'h0000
       && route_select_c_reg == 4'h0)
      |=> seq_pin_out == $past(pin_invert_select_reg))
      else $error("idle pins do not follow inversion bits");

   chk_setting_next_clk: assert property (@(posedge core_clk)
      disable iff (rst)
      $changed(pin_invert_select_reg) && $stable(route_select_a_reg)
      && $stable(route_select_b_reg) && $stable(route_select_c_reg)
      && $stable(status_in) && $stable(mode_reg)
      |=> seq_pin_out == ($past(seq_pin_out) ^
         $past(pin_invert_select_reg, 2) ^ $past(pin_invert_select_reg)))
      else $error("inversion change not seen on the next clock");

endmodule
`default_nettype wire

// ==== dv/host_relay_model.sv ====
`default_nettype none
module host_relay_model
   import router_pkg::*;
(
   input wire logic core_clk,
   input wire logic armed,
   input wire logic contact_1,
   input wire logic contact_2,
   input wire pulse_out_t pulse_out,
   output logic safe_stop_in_1,
   output logic safe_stop_in_2,
   output logic pair_fault
);
   timeunit 1ns;
   timeprecision 100ps;

   // -----------------------------------------------------------
   // Safety relay and host line receiver
   // -----------------------------------------------------------
   // Two separate relay contacts keep the stop inputs redundant
   assign safe_stop_in_1 = contact_1;
   assign safe_stop_in_2 = contact_2;

   // A receiver sees a broken pair when both wires sit level
   always @(posedge core_clk) begin
      if (!armed) begin
         pair_fault <= 1'b0;
      end else if (pulse_out.pulse_phase_a === pulse_out.pulse_phase_a_n ||
            pulse_out.pulse_phase_b === pulse_out.pulse_phase_b_n ||
            pulse_out.origin_pulse === pulse_out.origin_pulse_n) begin
         pair_fault <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`default_nettype none
module tb_top;
   import router_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   // -----------------------------------------------------------
   // Stimulus and observation
   // -----------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, irq, enc_pos_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic rerr, armed, contact_1, contact_2, ss1, ss2, pair_fault;
   logic [ENC_W-1:0] enc_pos;
   logic [NUM_PINS-1:0] seq_pin_out;
   logic safety_monitor_out, baseblock_out;
   status_sig_t status_in;
   pulse_out_t pulse_out;
   int mismatches = 0;
   int num_checks = 0;

   always #12.5 core_clk = ~core_clk;

   servo_output_signal_router #(.MONITOR_DELAY_CYCLES(16)) dut_u (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .status_in(status_in),
      .safe_stop_in_1(ss1), .safe_stop_in_2(ss2), .enc_pos(enc_pos),
      .enc_pos_valid(enc_pos_valid), .seq_pin_out(seq_pin_out),
      .safety_monitor_out(safety_monitor_out),
      .baseblock_out(baseblock_out), .pulse_out(pulse_out), .irq(irq));

   host_relay_model partner_u (
      .core_clk(core_clk), .armed(armed), .contact_1(contact_1),
      .contact_2(contact_2), .pulse_out(pulse_out), .safe_stop_in_1(ss1),
      .safe_stop_in_2(ss2), .pair_fault(pair_fault));

   // -----------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; holds everything until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdata, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   // Bounded wait for a pulse pattern, then judge it
   task automatic wait_pulse(input logic [5:0] exp);
      for (int n = 0; n < 64 && pulse_out !== exp; n++) begin
         @(negedge core_clk);
      end
      check(pulse_out, exp);
   endtask

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task automatic t_reset;
      check(seq_pin_out, 32'h0);
      check({safety_monitor_out, baseblock_out, irq}, 32'h2);
      check(pulse_out, 32'h15);
      rd(OFS_INVERT, 32'h0);
      rd(OFS_ROUTE_A, 32'h0);
      rd(8'h40, 32'h0);
      check(rerr, 32'h1);
   endtask

   // Every digit of the first selector, every pin code
   task automatic t_route_a;
      for (int d = 0; d < 4; d++) begin
         apb(1'b1, OFS_MODE, (d == 1) ? 32'h1 : 32'h0);
         for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFS_ROUTE_A, 32'(c) << (4 * d));
            status_in <= status_sig_t'(9'h1 << d);
            settle(2);
            check(seq_pin_out, (c == 0) ? 0 : 1 << (c - 1));
         end
      end
      apb(1'b1, OFS_ROUTE_A, 32'h0);
   endtask

   // Second and third selectors, OR on a shared pin, mode validity
   task automatic t_route_bc;
      logic [8:0] sv[6] = '{9'h010, 9'h020, 9'h030, 9'h040, 9'h080, 9'h0};
      logic [2:0] ex[6] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h4, 3'h0};
      apb(1'b1, OFS_MODE, 32'h2);
      apb(1'b1, OFS_ROUTE_B, 32'h3211);
      for (int i = 0; i < 6; i++) begin
         status_in <= status_sig_t'(sv[i]);
         settle(2);
         check(seq_pin_out, ex[i]);
      end
      apb(1'b1, OFS_ROUTE_B, 32'h0);
      apb(1'b1, OFS_ROUTE_C, 32'h2);
      status_in <= status_sig_t'(9'h100);
      settle(2);
      check(seq_pin_out, 32'h0);
      apb(1'b1, OFS_MODE, 32'h0);
      settle(1);
      check(seq_pin_out, 32'h2);
      apb(1'b1, OFS_ROUTE_C, 32'h0);
      apb(1'b1, OFS_ROUTE_A, 32'h3300);
      status_in <= status_sig_t'(9'h00C);
      settle(2);
      check(seq_pin_out, 32'h4);
      apb(1'b1, OFS_MODE, 32'h1);
      apb(1'b1, OFS_ROUTE_A, 32'h1);
      status_in <= status_sig_t'(9'h001);
      settle(2);
      check(seq_pin_out, 32'h0);
      apb(1'b1, OFS_MODE, 32'h0);
      apb(1'b1, OFS_ROUTE_A, 32'h0);
   endtask

   // Each inversion bit in turn flips its idle pin one clock after the write
   task automatic t_invert;
      status_in <= '0;
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, OFS_INVERT, 32'h1 << i);
         @(negedge core_clk);
         check(seq_pin_out, (i == 0) ? 0 : 1 << (i - 1));
         settle(1);
         check(seq_pin_out, 32'h1 << i);
      end
      apb(1'b1, OFS_INVERT, 32'h0);
   endtask

   // Contact combinations, then the sticky monitor events
   task automatic t_safety;
      logic [1:0] cv[4] = '{2'b10, 2'b01, 2'b00, 2'b11};
      for (int i = 0; i < 4; i++) begin
         {contact_1, contact_2} <= cv[i];
         settle(6);
         check(safety_monitor_out, &cv[i]);
         check(baseblock_out, ~&cv[i]);
      end
      rd(OFS_IRQ_STAT, 32'h7);
      check(irq, 32'h0);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      settle(2);
      check(irq, 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      settle(2);
      check(irq, 32'h0);
      rd(OFS_IRQ_STAT, 32'h6);
      apb(1'b1, OFS_IRQ_STAT, 32'h6);
   endtask

   // Two counts up, back to origin, one count down the short way
   task automatic t_encoder;
      logic [15:0] tv[3] = '{16'h0002, 16'h0000, 16'hFFFF};
      logic [5:0] pv[3] = '{6'h29, 6'h16, 6'h25};
      for (int i = 0; i < 3; i++) begin
         enc_pos <= tv[i];
         enc_pos_valid <= 1'b1;
         @(posedge core_clk);
         enc_pos_valid <= 1'b0;
         wait_pulse(pv[i]);
      end
      rd(OFS_IRQ_STAT, 32'h4);
      check(pair_fault, 32'h0);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // -----------------------------------------------------------
   // Sequence and watchdog
   // -----------------------------------------------------------
   initial begin
      {psel, penable, pwrite, enc_pos_valid, armed} = '0;
      {contact_1, contact_2} = 2'b11;
      paddr = '0;
      pwdata = '0;
      enc_pos = '0;
      status_in = '0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      armed = 1'b1;
      t_reset();
      t_route_a();
      t_route_bc();
      t_invert();
      t_safety();
      t_encoder();
      tally_and_finish();
   end

   // The whole run needs well under two thousand cycles
   initial begin
      #(25 * 5000);
      mismatches++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
